//--- rtl/orb_pkg.sv
// Package for the operational register bank: offsets, fields, resets, types
package orb_pkg;
  localparam int ADDR_W = 6;
  localparam logic [5:0] ADDR_INDIRECT = 6'h00;
  localparam logic [5:0] ADDR_TIMER = 6'h01;
  localparam logic [5:0] ADDR_PC_LOW = 6'h02;
  localparam logic [5:0] ADDR_STATUS = 6'h03;
  localparam logic [5:0] ADDR_RAM_SEL = 6'h04;
  localparam logic [5:0] ADDR_PORT5 = 6'h05;
  localparam logic [5:0] ADDR_PORT6 = 6'h06;
  localparam logic [5:0] ADDR_PORT7 = 6'h07;
  localparam logic [5:0] ADDR_PORT8 = 6'h08;
  localparam logic [5:0] ADDR_LCD_CTRL = 6'h09;
  localparam logic [5:0] ADDR_LCD_ADDR = 6'h0A;
  localparam logic [5:0] ADDR_LCD_DATA = 6'h0B;
  localparam logic [5:0] ADDR_GP_FIRST = 6'h10;
  localparam logic [5:0] ADDR_BANKED_FIRST = 6'h20;
  localparam int STATUS_TIMEOUT_BIT = 4;
  localparam int STATUS_PDOWN_BIT = 3;
  localparam logic [7:0] STATUS_WR_MASK = 8'h67;
  localparam logic [7:0] PORT5_MASK = 8'hF1;
  localparam logic [7:0] LCD_CTRL_MASK = 8'hF7;
  localparam logic [7:0] LCD_ADDR_MASK = 8'h1F;
  localparam logic [7:0] LCD_DATA_MASK = 8'h0F;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [11:0] PC_RESET = 12'h000;
  localparam int STACK_DEPTH = 8;
  localparam int GP_WORDS = 16;
  localparam int BANK_WORDS = 32;
  localparam int LCD_WORDS = 32;

  typedef enum logic [3:0] {
    ORB_OP_NONE = 4'h0,
    ORB_OP_JUMP = 4'h1,
    ORB_OP_CALL = 4'h2,
    ORB_OP_RET = 4'h3,
    ORB_OP_RETURN_LITERAL_INSTR = 4'h4,
    ORB_OP_RETURN_INTERRUPT_INSTR = 4'h5,
    ORB_OP_ADDPC = 4'h6,
    ORB_OP_MOVPC = 4'h7,
    ORB_OP_STEP = 4'h8
  } orb_op_type;

  typedef enum logic [1:0] {
    ORB_EV_NONE = 2'h0,
    ORB_EV_WDT_TIMEOUT = 2'h1,
    ORB_EV_WDT_WAKE = 2'h2,
    ORB_EV_PIN_WAKE = 2'h3
  } orb_event_type;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [5:0] addr;
    logic [7:0] wdata;
  } orb_access_type;

  typedef struct packed {
    orb_op_type op;
    logic [9:0] target;
    logic [7:0] acc;
    logic sleepInstr;
    logic watchdogClearInstr;
  } orb_ctrl_type;

  typedef struct packed {
    logic lcdBiasSel;
    logic [1:0] lcdDuty;
    logic lcdOn;
    logic lcdWaveSel;
    logic [1:0] frameRate;
    logic [8:0] frameDivisor;
  } orb_lcd_cfg_type;
endpackage : orb_pkg

//--- rtl/orb_return_stack.sv
// Eight-entry circular return stack that overwrites the oldest entry on overflow
`timescale 1ns/1ns
module orb_return_stack
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic push,
  input wire logic pop,
  input wire logic [11:0] pushData,
  output logic [11:0] topData
);
  logic [11:0] entries [orb_pkg::STACK_DEPTH];
  logic [2:0] topIdx;

  // Wrapping index: a ninth push replaces the oldest entry
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      topIdx <= 3'h7;
    end
    else if (push)
    begin
      topIdx <= topIdx + 3'h1;
    end
    else if (pop)
    begin
      topIdx <= topIdx - 3'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < orb_pkg::STACK_DEPTH; i++)
      begin
        entries[i] <= orb_pkg::PC_RESET;
      end
    end
    else if (push)
    begin
      entries[topIdx + 3'h1] <= pushData;
    end
  end

  assign topData = entries[topIdx];
endmodule : orb_return_stack

//--- rtl/orb_register_bank.sv
// Operational register bank at addresses 00h to 0Bh with program counter and paging
// Function
// - Address 00h has no register; it accesses the location the RAM select names.
// - Timer counter counts external edges or instruction cycles; program reads, writes it.
// - The nrst reset clears the whole program counter; powerOnReset leaves it unchanged.
// - Jump loads low ten counter bits from the instruction.
// - Call pushes next address and loads low ten counter bits.
// - Returns load full counter from stack top; page bits stay unchanged.
// - Adding accumulator to counter carries into bits 8 and 9 only.
// - Moving accumulator to counter replaces low eight bits and keeps bits 9:8.
// - Jump, call and counter changes copy page bits into counter bits 11:10.
// - Time-out bit set by sleep, watchdog clear, power up; cleared by timeout.
// - Power-down bit set at power on and watchdog clear; cleared by sleep.
// - Time-out/power-down read 00,01,10,11 for the four wake and reset causes.
// - RAM select bits 7:6 choose one of four banked areas.
// - RAM select low six bits address 64 locations; else plain byte.
// - Port 5 bit 0 selects control page 0 or 1.
// - Port 5 has bits 7:4, ports 6-8 eight bits; direction registers steer.
// - LCD bias bit 7 picks half bias at 0, third at 1.
// - Duty bits give half, third, or quarter duty when upper bit set.
// - LCD enable low disables the circuit and grounds all common lines; segment lines still follow the LCD address.
// - Frame-rate bits pick the divisor from the duty-dependent table.
// - Five-bit LCD address selects one of 32 segments; nibble drives commons.
// - LCD data buffer moves a low nibble; upper bits unused.
`timescale 1ns/1ns
module orb_register_bank
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic powerOnReset,
  input wire orb_pkg::orb_access_type access,
  input wire orb_pkg::orb_ctrl_type ctrl,
  input wire orb_pkg::orb_event_type wakeEvent,
  input wire logic timerCounterPin,
  input wire logic timerExtSel,
  input wire logic [7:0] port5_direction,
  input wire logic [7:0] port6_direction,
  input wire logic [7:0] port7_direction,
  input wire logic [7:0] port8_direction,
  input wire logic [7:0] port5PinIn,
  input wire logic [7:0] port6PinIn,
  input wire logic [7:0] port7PinIn,
  input wire logic [7:0] port8PinIn,
  output logic [7:0] rdata,
  output logic [11:0] programCounter,
  output logic control_page_sel,
  output logic [7:0] port5Out,
  output logic [7:0] port5Oe,
  output logic [7:0] port6Out,
  output logic [7:0] port6Oe,
  output logic [7:0] port7Out,
  output logic [7:0] port7Oe,
  output logic [7:0] port8Out,
  output logic [7:0] port8Oe,
  output orb_pkg::orb_lcd_cfg_type lcdCfg,
  output logic [3:0] lcdCommon,
  output logic [4:0] lcdSegment
);
  logic [7:0] timer_counter;
  logic [7:0] statusFlags;
  logic [7:0] ram_select;
  logic [7:0] port5Latch;
  logic [7:0] port6Latch;
  logic [7:0] port7Latch;
  logic [7:0] port8Latch;
  logic [7:0] lcdControl;
  logic [7:0] lcdAddress;
  logic [3:0] lcdMemory [orb_pkg::LCD_WORDS];
  logic [7:0] gpRam [orb_pkg::GP_WORDS];
  logic [7:0] bankRam [4][orb_pkg::BANK_WORDS];
  logic [2:0] tccSync;
  logic [7:0] p5Sync1, p5Sync2, p6Sync1, p6Sync2;
  logic [7:0] p7Sync1, p7Sync2, p8Sync1, p8Sync2;
  logic [11:0] stackTop;
  logic stackPush;
  logic stackPop;
  logic [5:0] effAddr;
  logic wrHit;
  logic [7:0] next_rdata;
  logic [11:0] next_programCounter;

  // Pins and the timer input cross into this domain through two flops
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tccSync <= 3'h0;
      p5Sync1 <= orb_pkg::REG_RESET;
      p5Sync2 <= orb_pkg::REG_RESET;
      p6Sync1 <= orb_pkg::REG_RESET;
      p6Sync2 <= orb_pkg::REG_RESET;
      p7Sync1 <= orb_pkg::REG_RESET;
      p7Sync2 <= orb_pkg::REG_RESET;
      p8Sync1 <= orb_pkg::REG_RESET;
      p8Sync2 <= orb_pkg::REG_RESET;
    end
    else
    begin
      tccSync <= {tccSync[1:0], timerCounterPin};
      p5Sync1 <= port5PinIn;
      p5Sync2 <= p5Sync1;
      p6Sync1 <= port6PinIn;
      p6Sync2 <= p6Sync1;
      p7Sync1 <= port7PinIn;
      p7Sync2 <= p7Sync1;
      p8Sync1 <= port8PinIn;
      p8Sync2 <= p8Sync1;
    end
  end

  // ==========================================================
  // Address resolution
  function automatic logic [7:0] pin_mix(input logic [7:0] latch, input logic [7:0] dir,
                                         input logic [7:0] pins);
    // Direction bit 1 means input, matching the port direction registers
    pin_mix = (pins & dir) | (latch & ~dir);
  endfunction : pin_mix

  assign effAddr = (access.addr == orb_pkg::ADDR_INDIRECT) ? ram_select[5:0] : access.addr;
  assign wrHit = access.wr;

  // ==========================================================
  // Timer counter
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      timer_counter <= orb_pkg::REG_RESET;
    end
    else if (wrHit && effAddr == orb_pkg::ADDR_TIMER)
    begin
      timer_counter <= access.wdata;
    end
    else if (timerExtSel ? (tccSync[1] && !tccSync[2]) : 1'b1)
    begin
      timer_counter <= timer_counter + 8'h01;
    end
  end

  // ==========================================================
  // Program counter and paging
  always_comb
  begin
    next_programCounter = programCounter + 12'h001;
    stackPush = 1'b0;
    stackPop = 1'b0;
    unique case (ctrl.op)
      orb_pkg::ORB_OP_JUMP:
        next_programCounter = {statusFlags[6:5], ctrl.target};
      orb_pkg::ORB_OP_CALL:
      begin
        next_programCounter = {statusFlags[6:5], ctrl.target};
        stackPush = 1'b1;
      end
      orb_pkg::ORB_OP_RET, orb_pkg::ORB_OP_RETURN_LITERAL_INSTR, orb_pkg::ORB_OP_RETURN_INTERRUPT_INSTR:
      begin
        next_programCounter = stackTop;
        stackPop = 1'b1;
      end
      orb_pkg::ORB_OP_ADDPC:
        next_programCounter = {statusFlags[6:5], 10'(programCounter[9:0] + {2'h0, ctrl.acc})};
      orb_pkg::ORB_OP_MOVPC:
        next_programCounter = {statusFlags[6:5], programCounter[9:8], ctrl.acc};
      orb_pkg::ORB_OP_STEP:
        next_programCounter = programCounter + 12'h001;
      default:
        next_programCounter = programCounter;
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      programCounter <= orb_pkg::PC_RESET;
    end
    else
    begin
      programCounter <= next_programCounter;
    end
  end

  orb_return_stack u_stack
  (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .push(stackPush),
    .pop(stackPop),
    .pushData(programCounter + 12'h001),
    .topData(stackTop)
  );

  // ==========================================================
  // Status register
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      // Pin reset reads 1,1 like power up
      statusFlags <= 8'h18;
    end
    else if (powerOnReset)
    begin
      statusFlags <= 8'h18;
    end
    else
    begin
      if (wrHit && effAddr == orb_pkg::ADDR_STATUS)
      begin
        statusFlags <= (access.wdata & orb_pkg::STATUS_WR_MASK) |
                       (statusFlags & ~orb_pkg::STATUS_WR_MASK);
      end
      // Hardware events follow so they win over a same-cycle write
      unique case (wakeEvent)
        orb_pkg::ORB_EV_WDT_WAKE:
        begin
          statusFlags[orb_pkg::STATUS_TIMEOUT_BIT] <= 1'b0;
          statusFlags[orb_pkg::STATUS_PDOWN_BIT] <= 1'b0;
        end
        orb_pkg::ORB_EV_WDT_TIMEOUT:
        begin
          statusFlags[orb_pkg::STATUS_TIMEOUT_BIT] <= 1'b0;
          statusFlags[orb_pkg::STATUS_PDOWN_BIT] <= 1'b1;
        end
        orb_pkg::ORB_EV_PIN_WAKE:
        begin
          statusFlags[orb_pkg::STATUS_TIMEOUT_BIT] <= 1'b1;
          statusFlags[orb_pkg::STATUS_PDOWN_BIT] <= 1'b0;
        end
        orb_pkg::ORB_EV_NONE:
        begin
          if (ctrl.sleepInstr)
          begin
            statusFlags[orb_pkg::STATUS_TIMEOUT_BIT] <= 1'b1;
            statusFlags[orb_pkg::STATUS_PDOWN_BIT] <= 1'b0;
          end
          else if (ctrl.watchdogClearInstr)
          begin
            statusFlags[orb_pkg::STATUS_TIMEOUT_BIT] <= 1'b1;
            statusFlags[orb_pkg::STATUS_PDOWN_BIT] <= 1'b1;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Plain registers, ports and LCD configuration
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ram_select <= orb_pkg::REG_RESET;
      port5Latch <= orb_pkg::REG_RESET;
      port6Latch <= orb_pkg::REG_RESET;
      port7Latch <= orb_pkg::REG_RESET;
      port8Latch <= orb_pkg::REG_RESET;
      lcdControl <= orb_pkg::REG_RESET;
      lcdAddress <= orb_pkg::REG_RESET;
    end
    else if (wrHit)
    begin
      unique case (effAddr)
        orb_pkg::ADDR_RAM_SEL: ram_select <= access.wdata;
        orb_pkg::ADDR_PORT5: port5Latch <= access.wdata & orb_pkg::PORT5_MASK;
        orb_pkg::ADDR_PORT6: port6Latch <= access.wdata;
        orb_pkg::ADDR_PORT7: port7Latch <= access.wdata;
        orb_pkg::ADDR_PORT8: port8Latch <= access.wdata;
        orb_pkg::ADDR_LCD_CTRL: lcdControl <= access.wdata & orb_pkg::LCD_CTRL_MASK;
        orb_pkg::ADDR_LCD_ADDR: lcdAddress <= access.wdata & orb_pkg::LCD_ADDR_MASK;
        default: ;
      endcase
    end
  end

  // General and banked data memory reached directly or through indirection
  always_ff @(posedge ref_clk)
  begin
    if (wrHit && effAddr >= orb_pkg::ADDR_BANKED_FIRST)
    begin
      bankRam[ram_select[7:6]][effAddr[4:0]] <= access.wdata;
    end
    else if (wrHit && effAddr >= orb_pkg::ADDR_GP_FIRST)
    begin
      gpRam[effAddr[3:0]] <= access.wdata;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (wrHit && effAddr == orb_pkg::ADDR_LCD_DATA)
    begin
      lcdMemory[lcdAddress[4:0]] <= access.wdata[3:0];
    end
  end

  // ==========================================================
  // Read path
  always_comb
  begin
    next_rdata = orb_pkg::REG_RESET;
    if (effAddr >= orb_pkg::ADDR_BANKED_FIRST)
    begin
      next_rdata = bankRam[ram_select[7:6]][effAddr[4:0]];
    end
    else if (effAddr >= orb_pkg::ADDR_GP_FIRST)
    begin
      next_rdata = gpRam[effAddr[3:0]];
    end
    else
    begin
      unique case (effAddr)
        orb_pkg::ADDR_TIMER: next_rdata = timer_counter;
        orb_pkg::ADDR_PC_LOW: next_rdata = programCounter[7:0];
        orb_pkg::ADDR_STATUS: next_rdata = statusFlags;
        orb_pkg::ADDR_RAM_SEL: next_rdata = ram_select;
        orb_pkg::ADDR_PORT5:
          next_rdata = pin_mix(port5Latch, port5_direction, p5Sync2) & orb_pkg::PORT5_MASK;
        orb_pkg::ADDR_PORT6: next_rdata = pin_mix(port6Latch, port6_direction, p6Sync2);
        orb_pkg::ADDR_PORT7: next_rdata = pin_mix(port7Latch, port7_direction, p7Sync2);
        orb_pkg::ADDR_PORT8: next_rdata = pin_mix(port8Latch, port8_direction, p8Sync2);
        orb_pkg::ADDR_LCD_CTRL: next_rdata = lcdControl;
        orb_pkg::ADDR_LCD_ADDR: next_rdata = lcdAddress;
        orb_pkg::ADDR_LCD_DATA: next_rdata = {4'h0, lcdMemory[lcdAddress[4:0]]};
        default: next_rdata = orb_pkg::REG_RESET;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rdata <= orb_pkg::REG_RESET;
    end
    else if (access.rd)
    begin
      rdata <= next_rdata;
    end
  end

  // ==========================================================
  // Registered outputs
  function automatic logic [8:0] frame_div(input logic [1:0] duty, input logic [1:0] rate);
    logic [8:0] divisor;
    divisor = 9'h000;
    unique case ({duty[1], duty[0] & ~duty[1], rate})
      4'b0000: divisor = 9'h100;
      4'b0001: divisor = 9'h118;
      4'b0010: divisor = 9'h130;
      4'b0011: divisor = 9'h0E8;
      4'b0100: divisor = 9'h0AC;
      4'b0101: divisor = 9'h0BC;
      4'b0110: divisor = 9'h0CC;
      4'b0111: divisor = 9'h09C;
      4'b1000: divisor = 9'h080;
      4'b1001: divisor = 9'h08C;
      4'b1010: divisor = 9'h098;
      4'b1011: divisor = 9'h074;
      default: divisor = 9'h080;
    endcase
    frame_div = divisor;
  endfunction : frame_div

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      control_page_sel <= 1'b0;
      port5Out <= orb_pkg::REG_RESET;
      port5Oe <= orb_pkg::REG_RESET;
      port6Out <= orb_pkg::REG_RESET;
      port6Oe <= orb_pkg::REG_RESET;
      port7Out <= orb_pkg::REG_RESET;
      port7Oe <= orb_pkg::REG_RESET;
      port8Out <= orb_pkg::REG_RESET;
      port8Oe <= orb_pkg::REG_RESET;
      lcdCfg <= '0;
      lcdCommon <= 4'h0;
      lcdSegment <= 5'h00;
    end
    else
    begin
      control_page_sel <= port5Latch[0];
      port5Out <= port5Latch & 8'hF0;
      port5Oe <= ~port5_direction & 8'hF0;
      port6Out <= port6Latch;
      port6Oe <= ~port6_direction;
      port7Out <= port7Latch;
      port7Oe <= ~port7_direction;
      port8Out <= port8Latch;
      port8Oe <= ~port8_direction;
      lcdCfg.lcdBiasSel <= lcdControl[7];
      lcdCfg.lcdDuty <= lcdControl[6:5];
      lcdCfg.lcdOn <= lcdControl[4];
      lcdCfg.lcdWaveSel <= lcdControl[2];
      lcdCfg.frameRate <= lcdControl[1:0];
      lcdCfg.frameDivisor <= frame_div(lcdControl[6:5], lcdControl[1:0]);
      lcdSegment <= lcdAddress[4:0];
      lcdCommon <= lcdControl[4] ? lcdMemory[lcdAddress[4:0]] : 4'h0;
    end
  end

  // ==========================================================
  // Checks
  chk_jump_page_load: assert property (@(posedge ref_clk) disable iff (!nrst)
    ctrl.op == orb_pkg::ORB_OP_JUMP && !powerOnReset |=>
    programCounter == {$past(statusFlags[6:5]), $past(ctrl.target)})
    else $error("jump target or page wrong");
  chk_movpc_keeps_high: assert property (@(posedge ref_clk) disable iff (!nrst)
    ctrl.op == orb_pkg::ORB_OP_MOVPC |=>
    programCounter[9:8] == $past(programCounter[9:8]) && programCounter[7:0] == $past(ctrl.acc))
    else $error("move to counter altered bits 9:8");
  chk_call_return_pair: assert property (@(posedge ref_clk) disable iff (!nrst)
    ctrl.op == orb_pkg::ORB_OP_CALL ##1 ctrl.op == orb_pkg::ORB_OP_RET |=>
    programCounter == $past(programCounter, 2) + 12'h001)
    else $error("return address wrong");
  chk_ret_keeps_page: assert property (@(posedge ref_clk) disable iff (!nrst)
    ctrl.op == orb_pkg::ORB_OP_RET && !access.wr && !powerOnReset |=>
    $stable(statusFlags[6:5]))
    else $error("return changed page bits");
  chk_sleep_flags: assert property (@(posedge ref_clk) disable iff (!nrst)
    ctrl.sleepInstr && wakeEvent == orb_pkg::ORB_EV_NONE && !powerOnReset |=>
    statusFlags[4:3] == 2'b10)
    else $error("sleep flags wrong");
  chk_wdt_timeout: assert property (@(posedge ref_clk) disable iff (!nrst)
    wakeEvent == orb_pkg::ORB_EV_WDT_TIMEOUT && !powerOnReset |=>
    statusFlags[4:3] == 2'b01)
    else $error("timeout flags wrong");
  chk_lcd_off_ground: assert property (@(posedge ref_clk) disable iff (!nrst)
    !lcdControl[4] |=> lcdCommon == 4'h0)
    else $error("commons driven while disabled");
  chk_timer_write: assert property (@(posedge ref_clk) disable iff (!nrst)
    wrHit && effAddr == orb_pkg::ADDR_TIMER |=> timer_counter == $past(access.wdata))
    else $error("timer write lost");
  cov_call_ret: cover property (@(posedge ref_clk) disable iff (!nrst)
    ctrl.op == orb_pkg::ORB_OP_CALL ##[1:8] ctrl.op == orb_pkg::ORB_OP_RET);
  cov_indirect_wr: cover property (@(posedge ref_clk) disable iff (!nrst)
    access.wr && access.addr == orb_pkg::ADDR_INDIRECT);
  cov_pin_wake: cover property (@(posedge ref_clk) disable iff (!nrst)
    wakeEvent == orb_pkg::ORB_EV_PIN_WAKE);
endmodule : orb_register_bank

//--- sim/orb_core_model.sv
// Behavioural instruction core driving register accesses and control strobes
`timescale 1ns/1ns
module orb_core_model
(
  input wire logic ref_clk,
  input wire logic [7:0] rdata,
  output orb_pkg::orb_access_type access,
  output orb_pkg::orb_ctrl_type ctrl,
  output orb_pkg::orb_event_type wakeEvent,
  output logic powerOnReset
);
  initial
  begin
    access = '0;
    ctrl = '0;
    wakeEvent = orb_pkg::ORB_EV_NONE;
    powerOnReset = 1'b0;
  end

  // A free cycle follows each strobe so two requests never merge
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    access <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge ref_clk);
    access <= '0;
    // One more edge so registered outputs already show the write
    @(posedge ref_clk);
    #1;
  endtask : wr

  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    access <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge ref_clk);
    access <= '0;
    @(posedge ref_clk);
    #1 d = rdata;
  endtask : rd

  task automatic step(input orb_pkg::orb_ctrl_type c, input orb_pkg::orb_event_type e);
    @(posedge ref_clk);
    ctrl <= c;
    wakeEvent <= e;
    @(posedge ref_clk);
    ctrl <= '0;
    wakeEvent <= orb_pkg::ORB_EV_NONE;
    @(posedge ref_clk);
    #1;
  endtask : step

  // Two instructions on consecutive edges, with no idle cycle between
  task automatic pair(input orb_pkg::orb_ctrl_type c1, input orb_pkg::orb_ctrl_type c2);
    @(posedge ref_clk);
    ctrl <= c1;
    @(posedge ref_clk);
    ctrl <= c2;
    @(posedge ref_clk);
    ctrl <= '0;
    @(posedge ref_clk);
    #1;
  endtask : pair

  task automatic por();
    @(posedge ref_clk);
    powerOnReset <= 1'b1;
    @(posedge ref_clk);
    powerOnReset <= 1'b0;
    @(posedge ref_clk);
    #1;
  endtask : por
endmodule : orb_core_model

//--- sim/testbench.sv
// Self-checking bench for the operational register bank
`timescale 1ns/1ns
module testbench;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic extSel = 1'b0;
  logic [7:0] dir = 8'h00;
  logic [7:0] pins = 8'h00;
  logic [7:0] rdata;
  logic [7:0] d;
  logic [11:0] pc;
  logic pageSel;
  logic [7:0] p6Out;
  logic [7:0] p6Oe;
  logic [7:0] p5Out;
  logic [7:0] p5Oe;
  logic [7:0] p8Out;
  logic powerOnReset;
  orb_pkg::orb_access_type access;
  orb_pkg::orb_ctrl_type ctrl;
  orb_pkg::orb_event_type wakeEvent;
  orb_pkg::orb_lcd_cfg_type lcdCfg;
  logic [3:0] lcdCommon;
  logic [4:0] lcdSegment;
  int err_count = 0;
  int checks = 0;
  int cycles = 0;

  always #5 ref_clk = ~ref_clk;

  orb_core_model core (.ref_clk(ref_clk), .rdata(rdata), .access(access), .ctrl(ctrl),
    .wakeEvent(wakeEvent), .powerOnReset(powerOnReset));

  orb_register_bank uut (.ref_clk(ref_clk), .nrst(nrst), .powerOnReset(powerOnReset),
    .access(access), .ctrl(ctrl), .wakeEvent(wakeEvent), .timerCounterPin(pins[0]),
    .timerExtSel(extSel), .port5_direction(dir), .port6_direction(dir),
    .port7_direction(dir), .port8_direction(dir), .port5PinIn(pins), .port6PinIn(pins),
    .port7PinIn(pins), .port8PinIn(pins), .rdata(rdata), .programCounter(pc),
    .control_page_sel(pageSel), .port5Out(p5Out), .port5Oe(p5Oe), .port6Out(p6Out),
    .port6Oe(p6Oe), .port7Out(), .port7Oe(), .port8Out(p8Out), .port8Oe(), .lcdCfg(lcdCfg),
    .lcdCommon(lcdCommon), .lcdSegment(lcdSegment));

  // ==========================================
  // Helpers
  task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string m);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic op(input orb_pkg::orb_op_type o, input logic [9:0] t, input logic [7:0] a);
    core.step('{o, t, a, 1'b0, 1'b0}, orb_pkg::ORB_EV_NONE);
  endtask : op

  task automatic ev(input logic s, input logic c, input orb_pkg::orb_event_type e,
    input logic [1:0] tp);
    core.step('{orb_pkg::ORB_OP_NONE, 10'h000, 8'h00, s, c}, e);
    core.rd(orb_pkg::ADDR_STATUS, d);
    chk(d[4:3], tp, "status T,P");
  endtask : ev

  // ==========================================
  // Scenarios
  task automatic t_reset();
    chk(pc, 12'h000, "pc after reset");
    core.rd(orb_pkg::ADDR_STATUS, d);
    chk(d, 8'h18, "status after reset");
    $display("test reset done");
  endtask : t_reset

  task automatic t_indirect();
    core.wr(orb_pkg::ADDR_RAM_SEL, 8'hE5);
    core.wr(orb_pkg::ADDR_INDIRECT, 8'hA5);
    core.rd(orb_pkg::ADDR_RAM_SEL, d);
    chk(d, 8'hE5, "ram select byte");
    core.wr(orb_pkg::ADDR_RAM_SEL, 8'h25);
    core.wr(orb_pkg::ADDR_INDIRECT, 8'h3C);
    core.wr(orb_pkg::ADDR_RAM_SEL, 8'hE5);
    core.rd(orb_pkg::ADDR_INDIRECT, d);
    chk(d, 8'hA5, "banked indirect");
    $display("test indirect done");
  endtask : t_indirect

  task automatic t_timer();
    core.wr(orb_pkg::ADDR_TIMER, 8'h10);
    core.rd(orb_pkg::ADDR_TIMER, d);
    // Counting every cycle: two edges pass between the write and the read sample
    chk(d, 8'h12, "timer cycle count");
    extSel <= 1'b1;
    core.wr(orb_pkg::ADDR_TIMER, 8'h40);
    pins <= 8'h01;
    core.rd(orb_pkg::ADDR_TIMER, d);
    core.rd(orb_pkg::ADDR_TIMER, d);
    chk(d, 8'h41, "timer pin edge");
    $display("test timer done");
  endtask : t_timer

  task automatic t_ports();
    core.wr(orb_pkg::ADDR_PORT5, 8'hFF);
    core.rd(orb_pkg::ADDR_PORT5, d);
    chk(d, 8'hF1, "port5 bits");
    chk(pageSel, 1'b1, "control page");
    chk(p5Out, 8'hF0, "port5 out bits");
    chk(p5Oe, 8'hF0, "port5 enable bits");
    core.wr(orb_pkg::ADDR_PORT6, 8'h5A);
    chk(p6Out, 8'h5A, "port6 out");
    chk(p6Oe, 8'hFF, "port6 enable");
    core.wr(orb_pkg::ADDR_PORT8, 8'hC3);
    chk(p8Out, 8'hC3, "port8 out");
    // Low nibble turned to inputs must read the pins, high nibble the latch
    dir <= 8'h0F;
    pins <= 8'h3C;
    core.rd(orb_pkg::ADDR_PORT6, d);
    core.rd(orb_pkg::ADDR_PORT6, d);
    chk(d, 8'h5C, "port6 mixed read");
    chk(p6Oe, 8'hF0, "port6 enable split");
    $display("test ports done");
  endtask : t_ports

  task automatic t_pc();
    core.wr(orb_pkg::ADDR_STATUS, 8'h60);
    op(orb_pkg::ORB_OP_JUMP, 10'h123, 8'h00);
    chk(pc, 12'hD23, "jump");
    core.wr(orb_pkg::ADDR_STATUS, 8'h20);
    for (int i = 0; i < 3; i++)
    begin
      op(orb_pkg::ORB_OP_CALL, 10'h045, 8'h00);
      chk(pc, 12'h445, "call");
      op(orb_pkg::orb_op_type'(4'h3 + i[3:0]), 10'h000, 8'h00);
      chk(pc, 12'hD24 + i[11:0], "return");
    end
    core.pair('{orb_pkg::ORB_OP_CALL, 10'h045, 8'h00, 1'b0, 1'b0},
      '{orb_pkg::ORB_OP_RET, 10'h000, 8'h00, 1'b0, 1'b0});
    chk(pc, 12'hD27, "back-to-back call and return");
    op(orb_pkg::ORB_OP_MOVPC, 10'h000, 8'h7F);
    chk(pc, 12'h57F, "move to pc");
    op(orb_pkg::ORB_OP_ADDPC, 10'h000, 8'h85);
    chk(pc, 12'h604, "add to pc");
    // Nine calls overflow the stack; eight returns still reach the second call's return
    for (int i = 0; i < 9; i++)
    begin
      op(orb_pkg::ORB_OP_CALL, 10'h045 + i[9:0], 8'h00);
    end
    for (int i = 0; i < 8; i++)
    begin
      op(orb_pkg::ORB_OP_RET, 10'h000, 8'h00);
    end
    chk(pc, 12'h446, "deepest kept return");
    nrst <= 1'b0;
    @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    #1;
    chk(pc, 12'h000, "pc after mid-run reset");
    $display("test pc done");
  endtask : t_pc

  task automatic t_status();
    ev(1'b1, 1'b0, orb_pkg::ORB_EV_NONE, 2'b10);
    core.por();
    core.rd(orb_pkg::ADDR_STATUS, d);
    chk(d[4:3], 2'b11, "power up T,P");
    ev(1'b0, 1'b0, orb_pkg::ORB_EV_WDT_WAKE, 2'b00);
    ev(1'b0, 1'b1, orb_pkg::ORB_EV_NONE, 2'b11);
    ev(1'b0, 1'b0, orb_pkg::ORB_EV_WDT_TIMEOUT, 2'b01);
    ev(1'b0, 1'b0, orb_pkg::ORB_EV_PIN_WAKE, 2'b10);
    $display("test status done");
  endtask : t_status

  task automatic t_lcd();
    core.wr(orb_pkg::ADDR_LCD_CTRL, 8'h90);
    core.wr(orb_pkg::ADDR_LCD_ADDR, 8'h1F);
    core.wr(orb_pkg::ADDR_LCD_DATA, 8'hFA);
    core.rd(orb_pkg::ADDR_LCD_DATA, d);
    chk(d, 8'h0A, "lcd nibble");
    chk(lcdSegment, 5'h1F, "lcd segment");
    chk(lcdCommon, 4'hA, "lcd commons");
    chk(lcdCfg.frameDivisor, 9'h100, "half duty divisor");
    chk(lcdCfg.lcdBiasSel, 1'b1, "bias");
    core.wr(orb_pkg::ADDR_LCD_CTRL, 8'h4B);
    core.rd(orb_pkg::ADDR_LCD_ADDR, d);
    chk(lcdCommon, 4'h0, "lcd off grounds");
    chk(lcdCfg.frameDivisor, 9'h074, "quarter duty divisor");
    core.wr(orb_pkg::ADDR_LCD_CTRL, 8'h31);
    chk(lcdCfg.frameDivisor, 9'h0BC, "third duty divisor");
    chk(lcdCfg.lcdOn, 1'b1, "lcd enable");
    $display("test lcd done");
  endtask : t_lcd

  // ==========================================
  // Run control
  task automatic complete_run();
    $display("TB: checks=%0d mismatches=%0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : complete_run

  // A hang ends the run well beyond the few hundred cycles the tests need
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_count++;
      complete_run();
    end
  end

  initial
  begin
    repeat (12) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    #1;
    t_reset();
    t_indirect();
    t_timer();
    t_ports();
    t_pc();
    t_status();
    t_lcd();
    complete_run();
  end
endmodule : testbench
